// File: src/wtc_pkg.sv
package wtc_pkg;
   // -----------------------------------------------------------------
   // widths and counts
   // -----------------------------------------------------------------
   localparam int WTC_W = 16;
   localparam int WTC_NCH = 3;
   localparam logic [15:0] WTC_BOTTOM = 16'h0000;
   localparam logic [15:0] WTC_CNT_RST = 16'h0000;
   localparam logic [15:0] WTC_PER_RST = 16'hffff;
   localparam logic [15:0] WTC_CMP_RST = 16'h0000;
   // -----------------------------------------------------------------
   // tick source select: divide by 2**sel
   // -----------------------------------------------------------------
   localparam int WTC_SEL_W = 3;
   localparam int WTC_PRE_W = 10;
   localparam logic [9:0] WTC_PRE_RST = 10'h000;
   // -----------------------------------------------------------------
   // wave shape select
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      WTC_NORMAL = 2'h0,
      WTC_TONE = 2'h1
   } wtc_shape_t;
endpackage

// File: src/wtc_timer.sv
`timescale 1ns/100ps
// Summary of operation
// - counter, cycle length, match values and buffers are 16 bits
// - compare counter with zero and cycle length for bottom and top
// - flags and wave changes from top, bottom, match land on next tick
// - tick comes from prescaled clock or from incoming events
// - with count-on-event enabled, events advance the counter
// - at update, valid buffers load unless freeze reload is set
// - count direction follows heading bit, changeable while running
// - counting up, top wraps to zero on next tick
// - counting down, bottom reloads the cycle length
// - software counter write is immediate and beats count or reload
// - each buffer has a valid flag, set on write, cleared at update
// - match registers and buffers both writable; direct write bypasses
// - unbuffered cycle length write takes effect at once
// - new top below counter while counting up forces wrap first
// - buffered cycle length changes only at update
// - match sets channel flag on next tick
// - buffered match copies at update, used from next count
// - waveform drives pin only with tone shape selected and output enabled
// - tone mode: match 0 sets period, outputs toggle on match
module wtc_timer
   import wtc_pkg::*;
(
   input wire logic ref_clk, // 200 MHz clock
   input wire logic reset_n, // async reset, active low
   input wire logic enable, // counter runs
   input wire logic [2:0] tick_source_select, // prescaler 2**sel
   input wire logic count_on_event_enable, // count events
   input wire logic event_in, // event pulse, same domain
   input wire logic count_down, // count heading bit
   input wire logic freeze_reload, // block updates
   input wire logic [1:0] wave_shape_select, // 0 none, 1 tone
   input wire logic [2:0] channel_output_enable, // per-channel override
   input wire logic [2:0] port_out, // normal pin values
   input wire logic cnt_wr, // write counter_value
   input wire logic per_wr, // write cycle length direct
   input wire logic cycle_length_buffer_wr, // write cycle length buffer
   input wire logic [2:0] cmp_wr, // write match value direct
   input wire logic [2:0] cmpbuf_wr, // write match buffer
   input wire logic [15:0] wr_data, // write data
   input wire logic [2:0] match_flag_clr, // clear match flags
   input wire logic ovf_flag_clr, // clear overflow flag
   output logic [15:0] counter_value, // counter
   output logic [15:0] cycle_length, // cycle length
   output logic [15:0] cycle_length_buffer, // its buffer
   output logic cycle_length_valid, // buffer valid
   output logic [47:0] match_value, // three match values
   output logic [47:0] match_buffer, // three match buffers
   output logic [2:0] match_buffer_valid, // buffer valid flags
   output logic [2:0] match_flag, // sticky match flags
   output logic ovf_flag, // sticky top/bottom flag
   output logic ovf_event, // event pulse on tick after top/bottom
   output logic [2:0] waveform_out, // waveform outputs
   output logic [2:0] pin_out // pin values after override
);
   import wtc_pkg::*;

   logic [9:0] pre_q, pre_d;
   logic [15:0] cnt_q, cnt_d, per_q, per_d, pbuf_q, pbuf_d;
   logic pbv_q, pbv_d, ovf_q, ovf_d, ovfe_q, ovfe_d;
   logic [15:0] cmp_q [3], cmp_d [3], cbuf_q [3], cbuf_d [3];
   logic [2:0] cbv_q, cbv_d, mf_q, mf_d, wo_q, wo_d;
   logic [2:0] hit_q, hit_d;
   logic top_hit_q, top_hit_d;
   logic tick, pre_tick, at_top, at_bot, upd, tone;
   logic [15:0] top_val;

   // -----------------------------------------------------------------
   // tick generation
   // -----------------------------------------------------------------
   always_comb
   begin
      pre_d = enable ? pre_q + 10'h001 : WTC_PRE_RST;
      pre_tick = enable &&
         ((pre_q & ((10'h001 << tick_source_select) - 10'h001)) == 10'h000);
      if (count_on_event_enable)
         tick = enable && event_in;
      else
         tick = pre_tick;
   end

   // -----------------------------------------------------------------
   // compare and counter
   // -----------------------------------------------------------------
   always_comb
   begin
      tone = (wave_shape_select == WTC_TONE);
      top_val = tone ? cmp_q[0] : per_q;
      at_top = (cnt_q == top_val);
      at_bot = (cnt_q == WTC_BOTTOM);
      // update at bottom counting down, at top counting up
      upd = tick && !freeze_reload
         && (count_down ? at_bot : at_top);
      cnt_d = cnt_q;
      if (tick)
      begin
         if (!count_down)
            // exact equality: a top below cnt runs through wrap first
            cnt_d = at_top ? WTC_BOTTOM
               : cnt_q + 16'h0001;
         else
            cnt_d = at_bot ? top_val
               : cnt_q - 16'h0001;
      end
      if (cnt_wr)
         cnt_d = wr_data;
      per_d = per_q;
      pbuf_d = pbuf_q;
      pbv_d = pbv_q;
      if (upd && pbv_q)
      begin
         per_d = pbuf_q;
         pbv_d = 1'b0;
      end
      if (cycle_length_buffer_wr)
      begin
         pbuf_d = wr_data;
         pbv_d = 1'b1;
      end
      if (per_wr)
         per_d = wr_data;
      top_hit_d = tick ? (at_top || at_bot) : top_hit_q;
      ovfe_d = tick && top_hit_q;
      ovf_d = ovfe_d || (ovf_q && !ovf_flag_clr);
   end

   // -----------------------------------------------------------------
   // match channels
   // -----------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < WTC_NCH; i++)
      begin
         cmp_d[i] = cmp_q[i];
         cbuf_d[i] = cbuf_q[i];
         cbv_d[i] = cbv_q[i];
         if (upd && cbv_q[i])
         begin
            cmp_d[i] = cbuf_q[i];
            cbv_d[i] = 1'b0;
         end
         if (cmpbuf_wr[i])
         begin
            cbuf_d[i] = wr_data;
            cbv_d[i] = 1'b1;
         end
         if (cmp_wr[i])
            cmp_d[i] = wr_data;
         // match is latched, then acted on the next tick
         hit_d[i] = tick ? (cnt_q == cmp_q[i]) : hit_q[i];
         mf_d[i] = (tick && hit_q[i])
            || (mf_q[i] && !match_flag_clr[i]);
         wo_d[i] = wo_q[i];
         if (!tone)
            wo_d[i] = 1'b0;
         else if (tick && hit_q[i])
            wo_d[i] = !wo_q[i];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pre_q <= WTC_PRE_RST;
         cnt_q <= WTC_CNT_RST;
         per_q <= WTC_PER_RST;
         pbuf_q <= WTC_PER_RST;
         pbv_q <= 1'b0;
         ovf_q <= 1'b0;
         ovfe_q <= 1'b0;
         top_hit_q <= 1'b0;
         cbv_q <= 3'h0;
         mf_q <= 3'h0;
         wo_q <= 3'h0;
         hit_q <= 3'h0;
         for (int i = 0; i < WTC_NCH; i++)
         begin
            cmp_q[i] <= WTC_CMP_RST;
            cbuf_q[i] <= WTC_CMP_RST;
         end
      end
      else
      begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         per_q <= per_d;
         pbuf_q <= pbuf_d;
         pbv_q <= pbv_d;
         ovf_q <= ovf_d;
         ovfe_q <= ovfe_d;
         top_hit_q <= top_hit_d;
         cbv_q <= cbv_d;
         mf_q <= mf_d;
         wo_q <= wo_d;
         hit_q <= hit_d;
         cmp_q <= cmp_d;
         cbuf_q <= cbuf_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   always_comb
   begin
      counter_value = cnt_q;
      cycle_length = per_q;
      cycle_length_buffer = pbuf_q;
      cycle_length_valid = pbv_q;
      match_value = {cmp_q[2], cmp_q[1], cmp_q[0]};
      match_buffer = {cbuf_q[2], cbuf_q[1], cbuf_q[0]};
      match_buffer_valid = cbv_q;
      match_flag = mf_q;
      ovf_flag = ovf_q;
      ovf_event = ovfe_q;
      waveform_out = wo_q;
      for (int i = 0; i < WTC_NCH; i++)
      begin
         if (tone && channel_output_enable[i])
            pin_out[i] = wo_q[i];
         else
            pin_out[i] = port_out[i];
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_wrap;
      tick && !count_down && at_top && !cnt_wr |=> cnt_q == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at top");

   property p_reload;
      tick && count_down && at_bot && !cnt_wr |=> cnt_q == $past(top_val);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");

   property p_cntwr;
      cnt_wr |=> cnt_q == $past(wr_data);
   endproperty
   a_cntwr: assert property (p_cntwr) else $error("write lost");

   property p_pbv;
      cycle_length_buffer_wr |=> cycle_length_valid;
   endproperty
   a_pbv: assert property (p_pbv) else $error("valid not set");

   property p_perupd;
      upd && pbv_q && !per_wr |=> per_q == $past(pbuf_q);
   endproperty
   a_perupd: assert property (p_perupd) else $error("no update");

   property p_freeze;
      freeze_reload && !per_wr |=> per_q == $past(per_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen");

   property p_flag;
      tick && hit_q[0] |=> match_flag[0];
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set");

   property p_hold;
      !tick && !cnt_wr |=> cnt_q == $past(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("stray count");

   property p_pin;
      !tone |-> pin_out == port_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin overridden");

   property p_mupd;
      upd && cbv_q[1] && !cmp_wr[1]
         |=> match_value[31:16] == $past(cbuf_q[1]);
   endproperty
   a_mupd: assert property (p_mupd) else $error("cmp stale");

   property p_ovfe;
      tick && top_hit_q |=> ovf_event;
   endproperty
   a_ovfe: assert property (p_ovfe) else $error("no ovf event");

   property p_tone;
      tone && tick && hit_q[0] |=> waveform_out[0] != $past(wo_q[0]);
   endproperty
   a_tone: assert property (p_tone) else $error("no toggle");

   property p_cmpwr;
      cmp_wr[0] |=> match_value[15:0] == $past(wr_data);
   endproperty
   a_cmpwr: assert property (p_cmpwr) else $error("cmp lost");

   property p_perwr;
      per_wr |=> cycle_length == $past(wr_data);
   endproperty
   a_perwr: assert property (p_perwr) else $error("per lost");

   property p_pvclr;
      upd && pbv_q && !cycle_length_buffer_wr |=> !cycle_length_valid;
   endproperty
   a_pvclr: assert property (p_pvclr) else $error("valid held");

   c_wrap: cover property (tick && at_top && !count_down);
   c_reload: cover property (tick && at_bot && count_down);
   c_toggle: cover property (tone && tick && hit_q[1]);
   c_update: cover property (upd && pbv_q);
   c_event: cover property (count_on_event_enable && tick);
endmodule

// File: dv/wtc_evt_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// event routing stand-in
// ---------------------------------------------
module wtc_evt_model
(
   input wire logic ref_clk, // clock
   input wire logic reset_n, // reset, active low
   input wire logic go, // start a burst
   input wire logic [3:0] burst, // pulses per burst
   output logic event_in, // one-cycle event
   output logic busy // burst in progress
);
   logic [4:0] left_q, left_d;
   logic ev_q, ev_d;
   always_comb
   begin
      ev_d = 1'b0;
      left_d = left_q;
      if (go)
         left_d = {burst, 1'b0};
      else if (left_q != 5'h00)
      begin
         left_d = left_q - 5'h01;
         ev_d = left_q[0]; // idle cycle between pulses
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         left_q <= 5'h00;
         ev_q <= 1'b0;
      end
      else
      begin
         left_q <= left_d;
         ev_q <= ev_d;
      end
   end
   assign event_in = ev_q;
   assign busy = ev_q | (left_q != 5'h00);
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
 $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   import wtc_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, en = 1'b0, ce = 1'b0, dn = 1'b0;
   logic frz = 1'b0, cw = 1'b0, pw = 1'b0, pbw = 1'b0, of_clr = 1'b0;
   logic go = 1'b0, ev, busy, of, oe;
   logic [2:0] sel = 3'h0, coe = 3'h0, po = 3'h6, cmw = 3'h0, cbw = 3'h0;
   logic [2:0] mcl = 3'h0, mbv, mf, wo, pin;
   logic [1:0] shp = 2'h0;
   logic [15:0] wd = 16'h0000, cnt, per, pbuf;
   logic pv, w;
   logic [47:0] mv, mb;
   int fail_count = 0, checks = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   wtc_evt_model evt_u (.ref_clk(ref_clk), .reset_n(reset_n), .go(go),
      .burst(4'h5), .event_in(ev), .busy(busy));
   wtc_timer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .enable(en),
      .tick_source_select(sel), .count_on_event_enable(ce), .event_in(ev),
      .count_down(dn), .freeze_reload(frz), .wave_shape_select(shp),
      .channel_output_enable(coe), .port_out(po), .cnt_wr(cw), .per_wr(pw),
      .cycle_length_buffer_wr(pbw), .cmp_wr(cmw), .cmpbuf_wr(cbw), .wr_data(wd),
      .match_flag_clr(mcl), .ovf_flag_clr(of_clr), .counter_value(cnt),
      .cycle_length(per), .cycle_length_buffer(pbuf),
      .cycle_length_valid(pv), .match_value(mv), .match_buffer(mb),
      .match_buffer_valid(mbv), .match_flag(mf), .ovf_flag(of),
      .ovf_event(oe), .waveform_out(wo), .pin_out(pin));
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // k: 0 counter, 1 length, 2 length buffer, 3..5 match, 6..8 buffer
   task automatic wr(input int k, input logic [15:0] d);
      @(negedge ref_clk);
      wd = d;
      {cw, pw, pbw} = 3'(4 >> k);
      cmw = 3'(1 << k >> 3);
      cbw = 3'(1 << k >> 6);
      @(negedge ref_clk);
      {cw, pw, pbw, cmw, cbw} = 9'h000;
   endtask
   task automatic wait_cnt(input logic [15:0] v);
      int i;
      for (i = 0; i < 300 && cnt !== v; i++)
         @(negedge ref_clk);
      `CHK("counter reached", v, cnt)
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      summarize();
   end
   initial
   begin
      cyc(8);
      reset_n = 1'b1;
      `CHK("cnt rst", WTC_CNT_RST, cnt)
      `CHK("per rst", WTC_PER_RST, per)
      `CHK("cmp rst", {3{WTC_CMP_RST}}, mv)
      `CHK("pin rst", po, pin)
      wr(1, 16'h0003);
      en = 1'b1;
      `CHK("per direct", 16'h0003, per)
      wait_cnt(16'h0003);
      cyc(1);
      `CHK("wrap", WTC_BOTTOM, cnt)
      `CHK("ovf event early", 1'b0, oe)
      cyc(1);
      `CHK("ovf event", 1'b1, oe)
      cyc(1);
      `CHK("ovf flag", 1'b1, of)
      {dn, of_clr} = 2'h3;
      cyc(1);
      of_clr = 1'b0;
      `CHK("ovf clr", 1'b0, of)
      wait_cnt(16'h0000);
      cyc(1);
      `CHK("reload", 16'h0003, cnt)
      dn = 1'b0;
      frz = 1'b1;
      wr(2, 16'h0005);
      `CHK("pbuf", 16'h0005, pbuf)
      `CHK("per valid", 1'b1, pv)
      wait_cnt(16'h0003);
      cyc(2);
      `CHK("frozen", 16'h0003, per)
      frz = 1'b0;
      wait_cnt(16'h0003);
      cyc(2);
      `CHK("per upd", 16'h0005, per)
      `CHK("valid clr", 1'b0, pv)
      wr(3, 16'h0002);
      `CHK("cmp direct", 16'h0002, mv[15:0])
      wr(7, 16'h0004);
      `CHK("cmp1 held", 16'h0000, mv[31:16])
      `CHK("cmp1 buf", 16'h0004, mb[31:16])
      `CHK("cmp1 valid", 3'h2, mbv)
      wait_cnt(16'h0005);
      cyc(2);
      `CHK("cmp1 upd", 16'h0004, mv[31:16])
      `CHK("match flag", 1'b1, mf[0])
      wait_cnt(16'h0004);
      mcl = 3'h1;
      cyc(1);
      mcl = 3'h0;
      `CHK("flag clr", 1'b0, mf[0])
      wr(0, 16'h0003);
      `CHK("cnt wr", 16'h0003, cnt)
      wr(1, 16'h0002);
      cyc(3);
      `CHK("no early wrap", 16'h0008, cnt)
      wr(1, 16'hffff);
      sel = 3'h2;
      wr(0, 16'h0000);
      cyc(8);
      `CHK("prescale", 16'h0002, cnt)
      ce = 1'b1;
      wr(0, 16'h0000);
      cyc(4);
      `CHK("no events", 16'h0000, cnt)
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      for (int i = 0; i < 40 && busy; i++) cyc(1);
      cyc(2);
      `CHK("events", 16'h0005, cnt)
      {ce, sel, coe, shp} = {1'b0, 3'h0, 3'h1, WTC_TONE};
      wr(0, 16'h0000);
      cyc(4);
      w = wo[0];
      cyc(3);
      `CHK("toggle", ~w, wo[0])
      `CHK("override", {po[2:1], wo[0]}, pin)
      shp = WTC_NORMAL;
      cyc(2);
      `CHK("no override", po, pin)
      summarize();
   end
endmodule
